/* rtl/gpio_line_ctrl.sv */
// Summary of operation
// (R1) writing software reset bit resets whole device
// (R2) software reset bit clears itself when done
// (R3) software reset hits every channel together
// (R4) gpio registers shared, channel select ignored
// (R5) control bit 2 maps low pins to modem b
// (R6) control bit 1 maps high pins to modem a
// (R7) modem pins ignore gpio interrupt enables
// (R8) unlatched: reverting input withdraws pending interrupt
// (R9) latched: interrupt and level held until read
// (R10) extra features reachable only with page bit zero
// (R11) ir mode clear: 3/16 bit pulses
// (R12) ir mode set: quarter bit pulses
// (R13) auto direction bit lets transmitter drive rts
// (R14) polarity clear: low transmitting, high receiving
// (R15) polarity set: high transmitting, low receiving
// (R16) reserved bits read zero, ignore writes
`timescale 1ns/10ps
`default_nettype none

module gpio_line_ctrl import line_ctrl_pkg::*; #(
  parameter logic [RST_CNT_W-1:0] SW_RESET_CYCLES = 3'h4
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // host register port
  input wire reg_req_type req,
  input wire logic [NUM_CH-1:0] page_sel,
  output logic [7:0] reg_rdata,
  // gpio pins
  input wire logic [GPIO_W-1:0] gpio_in,
  output logic [GPIO_W-1:0] gpio_out,
  output logic [GPIO_W-1:0] gpio_oe_b,
  output logic gpio_irq,
  // modem pins to and from the channels
  input wire logic terminal_ready_chan_a_b,
  input wire logic terminal_ready_chan_b_b,
  output modem_status_type modem_a,
  output modem_status_type modem_b,
  // serial side of each channel
  input wire serial_side_type [NUM_CH-1:0] ser,
  output logic [NUM_CH-1:0] ir_tx,
  output logic [NUM_CH-1:0] rts_b,
  output logic chan_reset
);

  state_type s_ff; // registered state
  state_type nxt_s; // next state
  logic [7:0] mmask; // pins taken by modem groups
  logic [7:0] elig; // pins allowed to raise interrupts
  logic [7:0] view; // pin state as the host sees it
  logic [7:0] chg; // eligible pins differing from reference
  logic rd_pin; // host read of pin state

  // pins taken over by modem groups
  function automatic logic [7:0] modem_mask(input logic sel_a, input logic sel_b);
    modem_mask = (sel_a ? GRP_A_MASK : 8'h00) | (sel_b ? GRP_B_MASK : 8'h00);
  endfunction

  // state after power-on reset or software reset
  function automatic state_type reset_state();
    state_type r;
    r = '0;
    r.dir = DIR_RST;
    r.pin_out = PIN_OUT_RST;
    r.ien = IEN_RST;
    r.ctl = CTL_RST;
    r.ref_lvl = REF_RST;
    r.gpio_out = PIN_OUT_RST;
    r.gpio_oe_b = ~DIR_RST;
    r.xfeat = {NUM_CH{XF_RST}};
    r.rts_b = '1;
    r.modem_a = '1;
    r.modem_b = '1;
    return r;
  endfunction

  // next state of the whole block
  always_comb begin
    nxt_s = s_ff;
    mmask = modem_mask(s_ff.ctl[CTL_MODEM_A], s_ff.ctl[CTL_MODEM_B]);
    elig = s_ff.ien & ~s_ff.dir & ~mmask; // R7
    // a pending latched pin shows the level that raised it
    view = s_ff.ctl[CTL_LATCH] ? ((s_ff.pend & s_ff.latched) | (~s_ff.pend & gpio_in)) : gpio_in; // R9
    chg = elig & (gpio_in ^ s_ff.ref_lvl);
    rd_pin = req.rd && (req.addr == OFS_PIN_STATE);
    // interrupt tracking
    if (s_ff.ctl[CTL_LATCH]) begin
      nxt_s.latched = view; // R9
      nxt_s.pend = (s_ff.pend | chg) & ~mmask; // R9 R7
    end else begin
      nxt_s.latched = gpio_in;
      nxt_s.pend = chg; // R8
    end
    // a read acknowledges: the shown level becomes the new reference
    if (rd_pin) begin
      nxt_s.ref_lvl = view;
      nxt_s.pend = '0;
    end
    nxt_s.irq = |nxt_s.pend;
    // read data, gpio registers ignore the channel select
    nxt_s.rdata = 8'h00;
    if (req.rd) begin
      unique case (req.addr)
        OFS_GPIO_DIR: nxt_s.rdata = s_ff.dir; // R4
        OFS_PIN_STATE: nxt_s.rdata = view; // R4
        OFS_PIN_IEN: nxt_s.rdata = s_ff.ien; // R4
        OFS_GPIO_CTL: nxt_s.rdata = {4'h0, s_ff.rst_cnt != '0, s_ff.ctl}; // R16 R2
        OFS_XFEAT: nxt_s.rdata = page_sel[req.chan] ? 8'h00 : (s_ff.xfeat[req.chan] & XF_RW_MASK); // R10 R16
        default: nxt_s.rdata = 8'h00; // unmapped offsets read zero
      endcase
    end
    // writes
    if (req.wr) begin
      unique case (req.addr)
        OFS_GPIO_DIR: nxt_s.dir = req.wdata; // R4
        OFS_PIN_STATE: nxt_s.pin_out = req.wdata; // R4
        OFS_PIN_IEN: nxt_s.ien = req.wdata; // R4
        OFS_GPIO_CTL: nxt_s.ctl = req.wdata[2:0]; // R16
        OFS_XFEAT: begin
          // other page holds a different register here
          if (!page_sel[req.chan]) begin
            nxt_s.xfeat[req.chan] = req.wdata & XF_RW_MASK; // R10 R16
          end
        end
        default: ; // writes to unmapped offsets are dropped
      endcase
    end
    // modem status pins, idle high when the group is plain gpio
    nxt_s.modem_a.ring_indicator_b = s_ff.ctl[CTL_MODEM_A] ? gpio_in[GRP_A_BASE + MDM_RI] : 1'b1; // R6
    nxt_s.modem_a.carrier_detect_b = s_ff.ctl[CTL_MODEM_A] ? gpio_in[GRP_A_BASE + MDM_CD] : 1'b1; // R6
    nxt_s.modem_a.dataset_ready_b = s_ff.ctl[CTL_MODEM_A] ? gpio_in[GRP_A_BASE + MDM_DSR] : 1'b1; // R6
    nxt_s.modem_b.ring_indicator_b = s_ff.ctl[CTL_MODEM_B] ? gpio_in[GRP_B_BASE + MDM_RI] : 1'b1; // R5
    nxt_s.modem_b.carrier_detect_b = s_ff.ctl[CTL_MODEM_B] ? gpio_in[GRP_B_BASE + MDM_CD] : 1'b1; // R5
    nxt_s.modem_b.dataset_ready_b = s_ff.ctl[CTL_MODEM_B] ? gpio_in[GRP_B_BASE + MDM_DSR] : 1'b1; // R5
    // pin drive: terminal ready pins are the only modem outputs
    nxt_s.gpio_out = (s_ff.pin_out & ~mmask)
                   | ({{3{terminal_ready_chan_a_b}}, 1'b0, {3{terminal_ready_chan_b_b}}, 1'b0} & ~8'h11
                      & DTR_PIN_MASK & mmask); // R5 R6
    nxt_s.gpio_oe_b = ~((s_ff.dir & ~mmask) | (DTR_PIN_MASK & mmask)); // R5 R6
    // per channel infrared pulse and rts direction
    for (int c = 0; c < NUM_CH; c++) begin
      if (ser[c].bit_start && !ser[c].tx_serial) begin
        nxt_s.ir_cnt[c] = s_ff.xfeat[c][XF_IR_FAST] ? IR_TICKS_FAST : IR_TICKS_STD; // R11 R12
      end else if (ser[c].tick16 && (s_ff.ir_cnt[c] != 3'h0)) begin
        nxt_s.ir_cnt[c] = s_ff.ir_cnt[c] - 3'h1;
      end
      nxt_s.ir_out[c] = nxt_s.ir_cnt[c] != 3'h0;
      if (s_ff.xfeat[c][XF_DIR_AUTO]) begin
        // polarity bit only matters under automatic direction
        nxt_s.rts_b[c] = s_ff.xfeat[c][XF_DIR_POL] ? ser[c].tx_active : !ser[c].tx_active; // R14 R15
      end else begin
        nxt_s.rts_b[c] = ser[c].rts_core_b; // R13
      end
    end
    // software reset overrides everything; host writes meanwhile are lost
    if (s_ff.rst_cnt != '0) begin
      nxt_s = reset_state(); // R1 R3
      nxt_s.rst_cnt = s_ff.rst_cnt - 3'h1; // R2
      nxt_s.chan_reset = nxt_s.rst_cnt != '0;
    end else if (req.wr && (req.addr == OFS_GPIO_CTL) && req.wdata[CTL_SWRST]) begin
      nxt_s = reset_state(); // R1 R3
      nxt_s.rst_cnt = SW_RESET_CYCLES;
      nxt_s.chan_reset = 1'b1; // R1
    end
  end

  // state register
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      s_ff <= reset_state();
    end else begin
      s_ff <= nxt_s;
    end
  end

  // outputs straight from the state register
  assign reg_rdata = s_ff.rdata;
  assign gpio_out = s_ff.gpio_out;
  assign gpio_oe_b = s_ff.gpio_oe_b;
  assign gpio_irq = s_ff.irq;
  assign modem_a = s_ff.modem_a;
  assign modem_b = s_ff.modem_b;
  assign ir_tx = s_ff.ir_out;
  assign rts_b = s_ff.rts_b;
  assign chan_reset = s_ff.chan_reset;

  // no software reset running or being started; a reset overrides every other output
  logic quiet;
  assign quiet = (s_ff.rst_cnt == '0) && !(req.wr && (req.addr == OFS_GPIO_CTL) && req.wdata[CTL_SWRST]);

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  property p_swrst_start;
    req.wr && req.addr == OFS_GPIO_CTL && req.wdata[CTL_SWRST] && s_ff.rst_cnt == '0 |=> chan_reset[*4] ##1 !chan_reset;
  endproperty
  a_swrst_start: assert property (p_swrst_start) else $error("software reset pulse wrong length"); // R1

  property p_swrst_clear;
    $fell(chan_reset) |-> s_ff.rst_cnt == '0 && s_ff.ctl == CTL_RST;
  endproperty
  a_swrst_clear: assert property (p_swrst_clear) else $error("software reset bit not cleared"); // R2

  property p_all_chan;
    chan_reset |-> s_ff.xfeat == '0 && s_ff.ien == IEN_RST && rts_b == '1;
  endproperty
  a_all_chan: assert property (p_all_chan) else $error("a channel survived software reset"); // R3

  property p_shared;
    req.wr && req.addr == OFS_PIN_IEN && req.chan && s_ff.rst_cnt == '0 |=> s_ff.ien == $past(req.wdata);
  endproperty
  a_shared: assert property (p_shared) else $error("shared register depends on channel"); // R4

  property p_modem_b;
    s_ff.ctl[CTL_MODEM_B] |=> gpio_oe_b[3:0] == 4'hd && modem_b.ring_indicator_b == $past(gpio_in[3]);
  endproperty
  a_modem_b: assert property (p_modem_b) else $error("low pins not mapped to modem b"); // R5

  property p_modem_a;
    s_ff.ctl[CTL_MODEM_A] |=> gpio_oe_b[7:4] == 4'hd && modem_a.carrier_detect_b == $past(gpio_in[6]);
  endproperty
  a_modem_a: assert property (p_modem_a) else $error("high pins not mapped to modem a"); // R6

  property p_modem_noint;
    $stable(s_ff.ctl) |-> (s_ff.pend & modem_mask(s_ff.ctl[CTL_MODEM_A], s_ff.ctl[CTL_MODEM_B])) == 8'h00;
  endproperty
  a_modem_noint: assert property (p_modem_noint) else $error("modem pin raised gpio interrupt"); // R7

  property p_nolatch_withdraw;
    !s_ff.ctl[CTL_LATCH] && gpio_in == s_ff.ref_lvl |=> s_ff.pend == 8'h00 ##1 !gpio_irq || s_ff.pend != 8'h00;
  endproperty
  a_nolatch_withdraw: assert property (p_nolatch_withdraw) else $error("unlatched interrupt not withdrawn"); // R8

  property p_latch_hold;
    s_ff.ctl[CTL_LATCH] && s_ff.pend[0] && !rd_pin && !req.wr && s_ff.rst_cnt == '0
      |=> s_ff.pend[0] && s_ff.latched[0] == $past(s_ff.latched[0]);
  endproperty
  a_latch_hold: assert property (p_latch_hold) else $error("latched interrupt lost"); // R9

  property p_xfeat_page;
    req.wr && req.addr == OFS_XFEAT && page_sel[req.chan] && s_ff.rst_cnt == '0 |=> $stable(s_ff.xfeat);
  endproperty
  a_xfeat_page: assert property (p_xfeat_page) else $error("extra features written on wrong page"); // R10

  property p_ir_std;
    ser[0].bit_start && !ser[0].tx_serial && !s_ff.xfeat[0][XF_IR_FAST] && quiet
      |=> s_ff.ir_cnt[0] == IR_TICKS_STD && ir_tx[0];
  endproperty
  a_ir_std: assert property (p_ir_std) else $error("standard ir pulse width wrong"); // R11

  property p_ir_fast;
    ser[0].bit_start && !ser[0].tx_serial && s_ff.xfeat[0][XF_IR_FAST] && quiet
      |=> s_ff.ir_cnt[0] == IR_TICKS_FAST && ir_tx[0];
  endproperty
  a_ir_fast: assert property (p_ir_fast) else $error("fast ir pulse width wrong"); // R12

  property p_rts_manual;
    !s_ff.xfeat[0][XF_DIR_AUTO] && quiet |=> rts_b[0] == $past(ser[0].rts_core_b);
  endproperty
  a_rts_manual: assert property (p_rts_manual) else $error("rts taken without auto direction"); // R13

  property p_rts_pol0;
    s_ff.xfeat[0][XF_DIR_AUTO] && !s_ff.xfeat[0][XF_DIR_POL] && quiet
      |=> rts_b[0] == !$past(ser[0].tx_active);
  endproperty
  a_rts_pol0: assert property (p_rts_pol0) else $error("rts not low while transmitting"); // R14

  property p_rts_pol1;
    s_ff.xfeat[0][XF_DIR_AUTO] && s_ff.xfeat[0][XF_DIR_POL] && quiet
      |=> rts_b[0] == $past(ser[0].tx_active);
  endproperty
  a_rts_pol1: assert property (p_rts_pol1) else $error("rts not high while transmitting"); // R15

  property p_reserved;
    $past(req.rd) && ($past(req.addr) == OFS_GPIO_CTL) && $past(s_ff.rst_cnt) == '0 |-> reg_rdata[7:4] == 4'h0;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved control bits not zero"); // R16

endmodule

`default_nettype wire

/* rtl/line_ctrl_pkg.sv */
package line_ctrl_pkg;

  // channel count and gpio width
  localparam int NUM_CH = 2;
  localparam int GPIO_W = 8;

  // register offsets on the host register port
  localparam logic [3:0] OFS_GPIO_DIR = 4'ha;
  localparam logic [3:0] OFS_PIN_STATE = 4'hb;
  localparam logic [3:0] OFS_PIN_IEN = 4'hc;
  localparam logic [3:0] OFS_GPIO_CTL = 4'he;
  localparam logic [3:0] OFS_XFEAT = 4'hf;

  // gpio_control bit positions
  localparam int CTL_LATCH = 0;
  localparam int CTL_MODEM_A = 1;
  localparam int CTL_MODEM_B = 2;
  localparam int CTL_SWRST = 3;

  // extra_features_control bit positions and writable bits
  localparam int XF_IR_FAST = 7;
  localparam int XF_DIR_POL = 5;
  localparam int XF_DIR_AUTO = 4;
  localparam logic [7:0] XF_RW_MASK = 8'hb7;

  // reset values
  localparam logic [7:0] DIR_RST = 8'h00;
  localparam logic [7:0] PIN_OUT_RST = 8'hff;
  localparam logic [7:0] IEN_RST = 8'h00;
  localparam logic [2:0] CTL_RST = 3'h0;
  localparam logic [7:0] XF_RST = 8'h00;
  localparam logic [7:0] REF_RST = 8'hff;

  // modem pin groups: channel a on the high nibble, channel b on the low one
  localparam logic [7:0] GRP_A_MASK = 8'hf0;
  localparam logic [7:0] GRP_B_MASK = 8'h0f;
  localparam logic [7:0] DTR_PIN_MASK = 8'h22;
  localparam int MDM_RI = 3;
  localparam int MDM_CD = 2;
  localparam int MDM_DSR = 0;
  localparam int GRP_A_BASE = 4;
  localparam int GRP_B_BASE = 0;

  // infrared pulse widths in 16x sample ticks
  localparam logic [2:0] IR_TICKS_STD = 3'h3;
  localparam logic [2:0] IR_TICKS_FAST = 3'h4;

  // software reset length counter width
  localparam int RST_CNT_W = 3;

  // host register request
  typedef struct packed {
    logic wr;
    logic rd;
    logic chan;
    logic [3:0] addr;
    logic [7:0] wdata;
  } reg_req_type;

  // per channel serial side signals from the channel core
  typedef struct packed {
    logic tx_serial;
    logic bit_start;
    logic tick16;
    logic tx_active;
    logic rts_core_b;
  } serial_side_type;

  // modem status pins handed to one channel, all active low
  typedef struct packed {
    logic ring_indicator_b;
    logic carrier_detect_b;
    logic dataset_ready_b;
  } modem_status_type;

  // complete block state
  typedef struct packed {
    logic [7:0] dir;
    logic [7:0] pin_out;
    logic [7:0] ien;
    logic [2:0] ctl;
    logic [RST_CNT_W-1:0] rst_cnt;
    logic [7:0] ref_lvl;
    logic [7:0] latched;
    logic [7:0] pend;
    logic [7:0] rdata;
    logic [7:0] gpio_out;
    logic [7:0] gpio_oe_b;
    logic irq;
    logic chan_reset;
    logic [NUM_CH-1:0][7:0] xfeat;
    logic [NUM_CH-1:0][2:0] ir_cnt;
    logic [NUM_CH-1:0] ir_out;
    logic [NUM_CH-1:0] rts_b;
    modem_status_type modem_a;
    modem_status_type modem_b;
  } state_type;

endpackage

/* tb/serial_partner.sv */
`timescale 1ns/10ps
`default_nettype none

module serial_partner import line_ctrl_pkg::*; (
  // clock
  input wire logic clk,
  // serial side toward the block
  output serial_side_type [NUM_CH-1:0] ser,
  input wire logic [NUM_CH-1:0] ir_tx,
  // 16x ticks seen while each infrared pulse was high
  output int ir_ticks [NUM_CH]
);
  logic tick = 1'b0; // 16x sample tick, every other cycle
  logic bs = 1'b0; // bit start pulse
  logic ts = 1'b1; // line idles at mark
  logic act = 1'b0; // transmitter busy

  // both channels send the same bit; the core rts stays low to tell manual mode apart
  always_comb begin
    for (int i = 0; i < NUM_CH; i++) begin
      ser[i] = '{tx_serial: ts, bit_start: bs, tick16: tick, tx_active: act, rts_core_b: 1'b0};
    end
  end

  // tick toggles off the sampling edge
  always @(negedge clk) begin
    tick <= ~tick;
  end

  // pulse width is counted in ticks the block really sampled; a bit start restarts it
  always @(posedge clk) begin
    for (int i = 0; i < NUM_CH; i++) begin
      if (bs) begin
        ir_ticks[i] = 0;
      end else if (ir_tx[i] && tick) begin
        ir_ticks[i]++;
      end
    end
  end

  // one zero bit of sixteen ticks, then back to idle
  task automatic send_bit();
    @(negedge clk);
    bs = 1'b1;
    ts = 1'b0;
    act = 1'b1;
    @(negedge clk);
    bs = 1'b0;
    repeat (31) @(negedge clk);
    ts = 1'b1;
    act = 1'b0;
  endtask
endmodule

`default_nettype wire

/* tb/tb_top.sv */
`timescale 1ns/10ps
`default_nettype none

module tb_top import line_ctrl_pkg::*;;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  reg_req_type req = '0;
  logic [NUM_CH-1:0] page_sel = '0;
  logic [GPIO_W-1:0] gpio_in = 8'hff;
  logic dtr_a_b = 1'b1;
  logic dtr_b_b = 1'b1;
  logic [7:0] reg_rdata;
  logic [GPIO_W-1:0] gpio_out;
  logic [GPIO_W-1:0] gpio_oe_b;
  logic gpio_irq;
  modem_status_type modem_a;
  modem_status_type modem_b;
  serial_side_type [NUM_CH-1:0] ser;
  logic [NUM_CH-1:0] ir_tx;
  logic [NUM_CH-1:0] rts_b;
  logic chan_reset;
  int ir_ticks [NUM_CH];
  int fails = 0;
  int check_count = 0;
  int cycles = 0;
  // extra features modes with the rts levels expected while sending and while idle
  logic [7:0] modes [5] = '{8'h00, 8'h10, 8'h30, 8'h20, 8'h80};
  logic [1:0] tx_rts [5] = '{2'b00, 2'b00, 2'b11, 2'b00, 2'b00};
  logic [1:0] idle_rts [5] = '{2'b00, 2'b11, 2'b00, 2'b00, 2'b00};

  // 250 MHz clock
  always #2 clk = ~clk;

  gpio_line_ctrl uut (.clk(clk), .rst_b(rst_b), .req(req), .page_sel(page_sel),
    .reg_rdata(reg_rdata), .gpio_in(gpio_in), .gpio_out(gpio_out), .gpio_oe_b(gpio_oe_b),
    .gpio_irq(gpio_irq), .terminal_ready_chan_a_b(dtr_a_b), .terminal_ready_chan_b_b(dtr_b_b),
    .modem_a(modem_a), .modem_b(modem_b), .ser(ser), .ir_tx(ir_tx), .rts_b(rts_b),
    .chan_reset(chan_reset));

  serial_partner partner (.clk(clk), .ser(ser), .ir_tx(ir_tx), .ir_ticks(ir_ticks));

  // verdict and end of run
  task automatic summarize();
    if (fails == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // compare a seen value with the expected one
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one-cycle write request, launched off the falling edge
  task automatic wr(input logic ch, input logic [3:0] a, input logic [7:0] d);
    @(negedge clk);
    req = '{wr: 1'b1, rd: 1'b0, chan: ch, addr: a, wdata: d};
    @(negedge clk);
    req = '0;
  endtask

  // one-cycle read; the data stands in the following cycle only
  task automatic rc(input logic ch, input logic [3:0] a, input logic [7:0] exp);
    @(negedge clk);
    req = '{wr: 1'b0, rd: 1'b1, chan: ch, addr: a, wdata: 8'h00};
    @(negedge clk);
    req = '0;
    chk(reg_rdata, exp);
  endtask

  // hang guard, well above the length of the sequence
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      fails++;
      summarize();
    end
  end

  initial begin
    repeat (6) @(negedge clk);
    rst_b = 1'b1;
    // reserved bits read zero, writable ones stick
    rc(1'b0, OFS_GPIO_CTL, 8'h00);
    wr(1'b0, OFS_GPIO_CTL, 8'hf0);
    rc(1'b0, OFS_GPIO_CTL, 8'h00);
    wr(1'b0, OFS_XFEAT, 8'hff);
    rc(1'b0, OFS_XFEAT, 8'hb7);
    // page bit hides the extra features register
    page_sel = 2'b10;
    wr(1'b1, OFS_XFEAT, 8'h91);
    rc(1'b1, OFS_XFEAT, 8'h00);
    page_sel = 2'b01;
    rc(1'b0, OFS_XFEAT, 8'h00);
    page_sel = 2'b00;
    rc(1'b1, OFS_XFEAT, 8'h00);
    // gpio registers look the same from both channels
    wr(1'b1, OFS_PIN_IEN, 8'h30);
    rc(1'b0, OFS_PIN_IEN, 8'h30);
    wr(1'b0, OFS_GPIO_DIR, 8'h0a);
    rc(1'b1, OFS_GPIO_DIR, 8'h0a);
    // output values written through the other channel drive only output pins
    wr(1'b1, OFS_PIN_STATE, 8'h5a);
    @(negedge clk);
    chk(gpio_out, 8'h5a);
    chk(gpio_oe_b, 8'hf5);
    wr(1'b0, OFS_GPIO_DIR, 8'h00);
    // high group as channel a modem pins; enables must not wake it
    wr(1'b1, OFS_PIN_IEN, 8'hf0);
    wr(1'b1, OFS_GPIO_CTL, 8'h02);
    gpio_in = 8'h7f;
    dtr_a_b = 1'b0;
    repeat (3) @(negedge clk);
    chk({5'h0, modem_a}, 8'h03);
    chk({6'h0, gpio_out[5], gpio_oe_b[5]}, 8'h00);
    chk({7'h0, gpio_irq}, 8'h00);
    gpio_in = 8'hff;
    wr(1'b0, OFS_PIN_IEN, 8'h00);
    // low group as channel b modem pins
    wr(1'b0, OFS_GPIO_CTL, 8'h04);
    gpio_in = 8'hf7;
    dtr_b_b = 1'b0;
    repeat (3) @(negedge clk);
    chk({5'h0, modem_b}, 8'h03);
    chk({5'h0, modem_a}, 8'h07);
    chk({6'h0, gpio_out[1], gpio_oe_b[1]}, 8'h00);
    gpio_in = 8'hff;
    wr(1'b0, OFS_GPIO_CTL, 8'h00);
    repeat (2) @(negedge clk);
    chk({5'h0, modem_b}, 8'h07);
    // unlatched: a pin that returns withdraws its interrupt
    wr(1'b0, OFS_PIN_IEN, 8'h01);
    gpio_in = 8'hfe;
    repeat (3) @(negedge clk);
    chk({7'h0, gpio_irq}, 8'h01);
    gpio_in = 8'hff;
    repeat (3) @(negedge clk);
    chk({7'h0, gpio_irq}, 8'h00);
    // latched: interrupt and the causing level stay until read
    wr(1'b0, OFS_GPIO_CTL, 8'h01);
    gpio_in = 8'hfe;
    repeat (3) @(negedge clk);
    gpio_in = 8'hff;
    repeat (3) @(negedge clk);
    chk({7'h0, gpio_irq}, 8'h01);
    rc(1'b0, OFS_PIN_STATE, 8'hfe);
    // infrared widths and rts direction control, both channels
    for (int m = 0; m < 5; m++) begin
      wr(1'b0, OFS_XFEAT, modes[m]);
      wr(1'b1, OFS_XFEAT, modes[m]);
      fork
        partner.send_bit();
        begin
          repeat (10) @(negedge clk);
          chk({6'h0, rts_b}, {6'h0, tx_rts[m]});
        end
      join
      repeat (3) @(negedge clk);
      chk({6'h0, rts_b}, {6'h0, idle_rts[m]});
      for (int c = 0; c < NUM_CH; c++) begin
        chk(8'(ir_ticks[c]), {5'h0, modes[m][7] ? IR_TICKS_FAST : IR_TICKS_STD});
      end
    end
    // software reset clears every channel and then itself
    wr(1'b1, OFS_XFEAT, 8'h13);
    wr(1'b0, OFS_PIN_IEN, 8'h55);
    wr(1'b0, OFS_GPIO_CTL, 8'h0f);
    chk({7'h0, chan_reset}, 8'h01);
    repeat (6) @(negedge clk);
    chk({7'h0, chan_reset}, 8'h00);
    rc(1'b0, OFS_GPIO_CTL, 8'h00);
    rc(1'b1, OFS_XFEAT, 8'h00);
    rc(1'b0, OFS_XFEAT, 8'h00);
    rc(1'b1, OFS_PIN_IEN, 8'h00);
    summarize();
  end
endmodule

`default_nettype wire
